/* hdl/tlic_ctrl_regs.sv */
`timescale 1ns/1ps
`include "tlic_map.svh"

module tlic_ctrl_regs #(
  parameter int RING_HOLD_CYC = `TLIC_RING_HOLD_CYC,
  parameter int GUARD_CYC     = `TLIC_OH_GUARD_CYC
) (
  input  wire logic               clk_sys,         // System clock, 10 MHz.
  input  wire logic               resetn,          // Synchronous reset, active low.
  input  wire tlic_pkg::tlic_req_s regReq,         // Register access from the serial port.
  output      logic [7:0]         rdData_q,        // Read data.
  output      logic               rdValid_q,       // Read data valid pulse.
  input  wire logic               ringPositive,    // Positive ring signal present.
  input  wire logic               ringNegative,    // Negative ring signal present.
  input  wire logic               offhookPin,      // External off-hook request pin.
  input  wire logic               offhookPinEnable,// Off-hook pin enable.
  input  wire logic               lineModeBit,     // Line mode bit.
  input  wire logic               frameValid,      // Serial data field strobe.
  input  wire logic               frameLsb,        // Least significant bit of that field.
  output      logic               secFrameReq_q,   // Secondary frame requested pulse.
  output      tlic_pkg::tlic_ctrl_s ctrl_q         // Control levels to the line side.
);
  import tlic_pkg::*;

  localparam int RW = $clog2(RING_HOLD_CYC + 1);
  localparam int GW = $clog2(GUARD_CYC + 1);

  // Whole reset bytes, so that each field's reset value is a plain bit select.
  localparam tlic_byte_t CTRL1_RST = `TLIC_CTRL1_RST;
  localparam tlic_byte_t CTRL2_RST = `TLIC_CTRL2_RST;
  localparam tlic_byte_t LINE1_RST = `TLIC_LINE1_RST;

  function automatic logic hitReg(input tlic_req_s r, input logic [7:0] a);
    hitReg = r.wr && (r.addr == a);
  endfunction

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic isoLoop_q, isoLoop_d, width_q, width_d;
  logic aloop_q, aloop_d, hybrid_q, hybrid_d, rxen_q, rxen_d;
  logic monitor_q, monitor_d, offBit_q, offBit_d;
  logic swRst;

  assign swRst = hitReg(regReq, `TLIC_ADDR_CTRL1) && regReq.data[`TLIC_BIT_SOFTRST];

  always_comb begin
    isoLoop_d = isoLoop_q;
    width_d   = width_q;
    aloop_d   = aloop_q;
    hybrid_d  = hybrid_q;
    rxen_d    = rxen_q;
    monitor_d = monitor_q;
    offBit_d  = offBit_q;
    if (swRst) begin
      isoLoop_d = CTRL1_RST[`TLIC_BIT_ISOLOOP];
      width_d   = CTRL1_RST[`TLIC_BIT_WIDTH];
      aloop_d   = CTRL2_RST[`TLIC_BIT_ALOOP];
      hybrid_d  = CTRL2_RST[`TLIC_BIT_HYBRID];
      rxen_d    = CTRL2_RST[`TLIC_BIT_RXEN];
      monitor_d = LINE1_RST[`TLIC_BIT_MONITOR];
      offBit_d  = LINE1_RST[`TLIC_BIT_OFFHOOK];
    end else begin
      if (hitReg(regReq, `TLIC_ADDR_CTRL1)) begin
        isoLoop_d = regReq.data[`TLIC_BIT_ISOLOOP];
        width_d   = width_q | regReq.data[`TLIC_BIT_WIDTH];
      end
      if (hitReg(regReq, `TLIC_ADDR_CTRL2)) begin
        aloop_d  = regReq.data[`TLIC_BIT_ALOOP];
        hybrid_d = regReq.data[`TLIC_BIT_HYBRID];
        rxen_d   = regReq.data[`TLIC_BIT_RXEN];
      end
      if (hitReg(regReq, `TLIC_ADDR_LINE1)) begin
        monitor_d = regReq.data[`TLIC_BIT_MONITOR];
        offBit_d  = regReq.data[`TLIC_BIT_OFFHOOK];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      isoLoop_q <= 1'b0;
      width_q   <= 1'b0;
      aloop_q   <= 1'b0;
      hybrid_q  <= 1'b1;
      rxen_q    <= 1'b1;
      monitor_q <= 1'b0;
      offBit_q  <= 1'b0;
    end else begin
      isoLoop_q <= isoLoop_d;
      width_q   <= width_d;
      aloop_q   <= aloop_d;
      hybrid_q  <= hybrid_d;
      rxen_q    <= rxen_d;
      monitor_q <= monitor_d;
      offBit_q  <= offBit_d;
    end
  end

  // --------------------------------------------------------------------------
  // Hook control
  // --------------------------------------------------------------------------
  // A drop of the request holds the line on-hook for the guard time so that a
  // quick re-request cannot flash the line; line mode skips that wait.
  tlic_hook_e      hook_q, hook_d;
  logic [GW-1:0]   guard_q, guard_d;
  logic            offReq;

  assign offReq = offBit_d | (offhookPinEnable & offhookPin);

  always_comb begin
    hook_d  = hook_q;
    guard_d = guard_q;
    case (hook_q)
      TLIC_ONHOOK: begin
        if (offReq) begin
          hook_d = TLIC_OFFHOOK;
        end
      end
      TLIC_OFFHOOK: begin
        if (!offReq) begin
          if (lineModeBit) begin
            hook_d = TLIC_ONHOOK;
          end else begin
            hook_d  = TLIC_GUARD;
            guard_d = GW'(GUARD_CYC);
          end
        end
      end
      TLIC_GUARD: begin
        if (guard_q <= GW'(1)) begin
          guard_d = '0;
          hook_d  = TLIC_ONHOOK;
        end else begin
          guard_d = guard_q - GW'(1);
        end
      end
      default: begin
        hook_d  = TLIC_ONHOOK;
        guard_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hook_q  <= TLIC_ONHOOK;
      guard_q <= '0;
    end else begin
      hook_q  <= hook_d;
      guard_q <= guard_d;
    end
  end

  // --------------------------------------------------------------------------
  // Ring detect
  // --------------------------------------------------------------------------
  logic          ringFlag_q, ringFlag_d;
  logic [RW-1:0] ringCnt_q, ringCnt_d;

  always_comb begin
    ringFlag_d = ringFlag_q;
    ringCnt_d  = ringCnt_q;
    if (ringCnt_q != '0) begin
      ringCnt_d = ringCnt_q - RW'(1);
    end
    if (ringPositive) begin
      ringCnt_d = RW'(RING_HOLD_CYC);
    end
    if (swRst || hook_q == TLIC_OFFHOOK || ringCnt_q == RW'(1)) begin
      ringFlag_d = 1'b0;
    end
    // A ring arriving in the clearing cycle still wins.
    if (ringPositive || ringNegative) begin
      ringFlag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ringFlag_q <= 1'b0;
      ringCnt_q  <= '0;
    end else begin
      ringFlag_q <= ringFlag_d;
      ringCnt_q  <= ringCnt_d;
    end
  end

  // --------------------------------------------------------------------------
  // Read path and outputs
  // --------------------------------------------------------------------------
  logic [7:0] rdData_d, rdByte;
  logic       rdValid_d, secFrame_d;
  tlic_ctrl_s ctrl_d;

  always_comb begin
    rdByte = 8'h00;
    case (regReq.addr)
      `TLIC_ADDR_CTRL1: begin
        rdByte[`TLIC_BIT_ISOLOOP] = isoLoop_q;
        rdByte[`TLIC_BIT_WIDTH]   = width_q;
      end
      `TLIC_ADDR_CTRL2: begin
        rdByte[`TLIC_BIT_ALOOP]  = aloop_q;
        rdByte[`TLIC_BIT_HYBRID] = hybrid_q;
        rdByte[`TLIC_BIT_RXEN]   = rxen_q;
      end
      `TLIC_ADDR_LINE1: begin
        rdByte[`TLIC_BIT_RINGNEG] = ringNegative;
        rdByte[`TLIC_BIT_RINGPOS] = ringPositive;
        rdByte[`TLIC_BIT_MONITOR] = monitor_q;
        rdByte[`TLIC_BIT_RINGDET] = ringFlag_q;
        rdByte[`TLIC_BIT_OFFHOOK] = offBit_q;
      end
      default: begin
        rdByte = 8'h00;
      end
    endcase
    rdValid_d  = regReq.rd;
    rdData_d   = regReq.rd ? rdByte : rdData_q;
    secFrame_d = frameValid && frameLsb && !width_q;
    ctrl_d.isoLoopback    = isoLoop_d;
    ctrl_d.serialWidth16  = width_d;
    ctrl_d.analogLoopback = aloop_d;
    ctrl_d.hybridConnect  = hybrid_d;
    ctrl_d.rxEnable       = rxen_d;
    ctrl_d.lineMonitor    = monitor_d;
    ctrl_d.offhookDrive   = (hook_d == TLIC_OFFHOOK);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdData_q      <= 8'h00;
      rdValid_q     <= 1'b0;
      secFrameReq_q <= 1'b0;
      ctrl_q        <= 7'h0c;
    end else begin
      rdData_q      <= rdData_d;
      rdValid_q     <= rdValid_d;
      secFrameReq_q <= secFrame_d;
      ctrl_q        <= ctrl_d;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_softWrite;
    regReq.wr && regReq.addr == `TLIC_ADDR_CTRL1 && regReq.data[7];
  endsequence

  sequence s_lineRead;
    regReq.rd && regReq.addr == `TLIC_ADDR_LINE1;
  endsequence

  // The hook drive and the ring flag may legally stay up through a soft reset: the
  // enabled pin keeps its off-hook request and a ring in the same cycle still sets.
  a_softrst_restores: assert property (s_softWrite |=> ctrl_q[6:1] == 6'h06 && !offBit_q
    && ringFlag_q == $past(ringPositive || ringNegative))
    else $error("soft reset did not restore controls");
  a_isoloop_follows: assert property (regReq.wr && regReq.addr == `TLIC_ADDR_CTRL1 && !regReq.data[7]
    |=> ctrl_q.isoLoopback == $past(regReq.data[1]))
    else $error("isolation loopback does not follow write");
  a_width_sticky: assert property (ctrl_q.serialWidth16 && !swRst |=> ctrl_q.serialWidth16)
    else $error("serial width bit cleared without reset");
  a_frame_request: assert property (frameValid && frameLsb |=> secFrameReq_q == !$past(width_q))
    else $error("secondary frame request wrong for width mode");
  a_wide_nosec: assert property (width_q |=> !secFrameReq_q)
    else $error("secondary frame requested in 16-bit mode");
  a_ctrl2_write: assert property (regReq.wr && regReq.addr == `TLIC_ADDR_CTRL2 && !swRst
    |=> {ctrl_q.analogLoopback, ctrl_q.hybridConnect, ctrl_q.rxEnable} == $past({regReq.data[3], regReq.data[1:0]}))
    else $error("control two bits do not follow write");
  a_ring_live_read: assert property (s_lineRead |=> rdValid_q && rdData_q[6:5] == $past({ringNegative, ringPositive}))
    else $error("ring signal bits misread");
  a_ring_sets: assert property (ringPositive || ringNegative |=> ringFlag_q)
    else $error("ring detect did not set");
  a_ring_offclear: assert property (hook_q == TLIC_OFFHOOK && !ringPositive && !ringNegative |=> !ringFlag_q)
    else $error("ring detect not cleared by off-hook");
  a_offhook_or: assert property (hook_q == TLIC_ONHOOK && offhookPinEnable && offhookPin |=> ctrl_q.offhookDrive)
    else $error("enabled off-hook pin ignored");
  a_mode_noguard: assert property (hook_q == TLIC_OFFHOOK && !offReq && lineModeBit |=> hook_q == TLIC_ONHOOK)
    else $error("guard counter started in line mode");
  a_guard_bound: assert property (hook_q == TLIC_OFFHOOK && !offReq && !lineModeBit |=> !ctrl_q.offhookDrive[*2])
    else $error("line went off-hook during guard");
  a_reserved_zero: assert property (regReq.rd && (regReq.addr == `TLIC_ADDR_RSVD3 || regReq.addr == `TLIC_ADDR_RSVD4)
    |=> rdData_q == 8'h00)
    else $error("reserved register read nonzero");

endmodule // tlic_ctrl_regs

/* hdl/tlic_map.svh */
`ifndef TLIC_MAP_SVH
`define TLIC_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TLIC_ADDR_CTRL1       8'h01
`define TLIC_ADDR_CTRL2       8'h02
`define TLIC_ADDR_RSVD3       8'h03
`define TLIC_ADDR_RSVD4       8'h04
`define TLIC_ADDR_LINE1       8'h05

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TLIC_CTRL1_RST        8'h00
`define TLIC_CTRL2_RST        8'h03
`define TLIC_LINE1_RST        8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TLIC_BIT_SOFTRST      7
`define TLIC_BIT_ISOLOOP      1
`define TLIC_BIT_WIDTH        0
`define TLIC_BIT_ALOOP        3
`define TLIC_BIT_HYBRID       1
`define TLIC_BIT_RXEN         0
`define TLIC_BIT_RINGNEG      6
`define TLIC_BIT_RINGPOS      5
`define TLIC_BIT_MONITOR      3
`define TLIC_BIT_RINGDET      2
`define TLIC_BIT_OFFHOOK      0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TLIC_CLK_PERIOD_NS    100
`define TLIC_RING_HOLD_MS     4500
`define TLIC_RING_HOLD_CYC    ((`TLIC_RING_HOLD_MS * 1000) * (1000 / `TLIC_CLK_PERIOD_NS))
`define TLIC_OH_GUARD_US      250
`define TLIC_OH_GUARD_CYC     ((`TLIC_OH_GUARD_US * 1000 + `TLIC_CLK_PERIOD_NS - 1) / `TLIC_CLK_PERIOD_NS)

`endif

/* hdl/tlic_pkg.sv */
package tlic_pkg;

  typedef logic [7:0] tlic_byte_t;

  // One register access from the serial port front end.
  typedef struct packed {
    logic       wr;
    logic       rd;
    tlic_byte_t addr;
    tlic_byte_t data;
  } tlic_req_s;

  // Control levels handed to the line-facing logic.
  typedef struct packed {
    logic isoLoopback;
    logic serialWidth16;
    logic analogLoopback;
    logic hybridConnect;
    logic rxEnable;
    logic lineMonitor;
    logic offhookDrive;
  } tlic_ctrl_s;

  typedef enum logic [1:0] {
    TLIC_ONHOOK  = 2'b00,
    TLIC_OFFHOOK = 2'b01,
    TLIC_GUARD   = 2'b10
  } tlic_hook_e;

endpackage

/* tb/tlic_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Host side of the register path
// ----------------------------------------------------------------------------
module tlic_host_model (
  input  wire logic                clk_sys, // System clock.
  output      tlic_pkg::tlic_req_s regReq   // Register access toward the block.
);
  import tlic_pkg::*;

  initial regReq = '0;

  // The address and data are inverted once released and wr and rd drop, so a stale address can never pass for a held one.
  task automatic access(input logic w, input tlic_byte_t a, input tlic_byte_t d);
    @(posedge clk_sys);
    regReq <= '{wr: w, rd: ~w, addr: a, data: d};
    @(posedge clk_sys);
    regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask

  task automatic writeReg(input tlic_byte_t a, input tlic_byte_t d);
    access(1'b1, a, d);
  endtask

  task automatic readReg(input tlic_byte_t a);
    access(1'b0, a, 8'h00);
  endtask
endmodule // tlic_host_model

/* tb/testbench.sv */
`timescale 1ns/1ps

module testbench;
  import tlic_pkg::*;
  logic       clk_sys          = 1'b0;
  logic       resetn           = 1'b0;
  logic       ringPositive     = 1'b0;
  logic       ringNegative     = 1'b0;
  logic       offhookPin       = 1'b0;
  logic       offhookPinEnable = 1'b0;
  logic       lineModeBit      = 1'b0;
  logic       frameValid       = 1'b0;
  logic       frameLsb         = 1'b0;
  tlic_req_s  regReq;
  tlic_byte_t rdData_q;
  logic       rdValid_q;
  logic       secFrameReq_q;
  tlic_ctrl_s ctrl_q;
  tlic_byte_t expQ[$];
  tlic_byte_t v;
  tlic_byte_t rsvAddr[3] = '{8'h03, 8'h04, 8'hff};
  int         errTotal  = 0;
  int         nCompared = 0;
  int         cycles    = 0;

  always #50 clk_sys = ~clk_sys;

  tlic_host_model host (.clk_sys(clk_sys), .regReq(regReq));

  tlic_ctrl_regs #(.RING_HOLD_CYC(20), .GUARD_CYC(4)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .regReq(regReq), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
    .ringPositive(ringPositive), .ringNegative(ringNegative), .offhookPin(offhookPin),
    .offhookPinEnable(offhookPinEnable), .lineModeBit(lineModeBit), .frameValid(frameValid),
    .frameLsb(frameLsb), .secFrameReq_q(secFrameReq_q), .ctrl_q(ctrl_q));

  // ----------------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------------
  task automatic completeRun();
    if (errTotal == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input tlic_byte_t exp, input tlic_byte_t got);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  always @(negedge clk_sys) begin
    if (rdValid_q === 1'b1) begin
      if (expQ.size() == 0) begin
        chk("rdValid", 8'h00, 8'h01);
      end else begin
        chk("rdData", expQ.pop_front(), rdData_q);
      end
    end
  end

  // The ceiling is more than ten times the length of the sequence below.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      errTotal++;
      completeRun();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic rd(input tlic_byte_t a, input tlic_byte_t e);
    expQ.push_back(e);
    host.readReg(a);
  endtask

  task automatic frame(input logic e);
    @(posedge clk_sys);
    frameValid <= 1'b1;
    frameLsb <= 1'b1;
    @(posedge clk_sys);
    frameValid <= 1'b0;
    @(negedge clk_sys);
    chk("secFrameReq", {7'h00, e}, {7'h00, secFrameReq_q});
  endtask

  task automatic hook(input logic e);
    chk("offhookDrive", {7'h00, e}, {7'h00, ctrl_q.offhookDrive});
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    v = 8'($urandom(8));
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    cyc(1);
    chk("ctrl", 8'h0c, {1'b0, ctrl_q});
    for (int i = 0; i < 6; i++) begin
      rd(8'(i), (i == 2) ? 8'h03 : 8'h00);
    end
    foreach (rsvAddr[i]) begin
      host.writeReg(rsvAddr[i], 8'($urandom));
      rd(rsvAddr[i], 8'h00);
    end
    repeat (4) begin
      v = 8'($urandom);
      host.writeReg(8'h02, v);
      cyc(2);
      chk("ctrl", {3'b000, v[3], v[1], v[0], 2'b00}, {1'b0, ctrl_q});
      rd(8'h02, v & 8'h0b);
    end
    // Line side is taken as already enabled here.
    host.writeReg(8'h01, 8'h02);
    cyc(2);
    chk("isoLoopback", 8'h01, {7'h00, ctrl_q.isoLoopback});
    frame(1'b1);
    host.writeReg(8'h01, 8'h01);
    rd(8'h01, 8'h01);
    host.writeReg(8'h01, 8'h00);
    rd(8'h01, 8'h01);
    cyc(1);
    chk("serialWidth16", 8'h01, {7'h00, ctrl_q.serialWidth16});
    frame(1'b0);
    // Soft reset brings the port back to 15-bit framing.
    host.writeReg(8'h01, 8'h80);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h03);
    frame(1'b1);
    host.writeReg(8'h05, 8'hf8);
    rd(8'h05, 8'h08);
    cyc(1);
    chk("lineMonitor", 8'h01, {7'h00, ctrl_q.lineMonitor});
    host.writeReg(8'h05, 8'h00);
    host.writeReg(8'h05, 8'h01);
    rd(8'h05, 8'h01);
    hook(1'b1);
    host.writeReg(8'h05, 8'h00);
    @(posedge clk_sys);
    ringPositive <= 1'b1;
    cyc(3);
    rd(8'h05, 8'h24);
    @(posedge clk_sys);
    ringPositive <= 1'b0;
    ringNegative <= 1'b1;
    cyc(2);
    rd(8'h05, 8'h44);
    @(posedge clk_sys);
    ringNegative <= 1'b0;
    cyc(3);
    rd(8'h05, 8'h04);
    cyc(50);
    rd(8'h05, 8'h00);
    @(posedge clk_sys);
    ringPositive <= 1'b1;
    @(posedge clk_sys);
    ringPositive <= 1'b0;
    host.writeReg(8'h05, 8'h01);
    cyc(3);
    rd(8'h05, 8'h01);
    host.writeReg(8'h05, 8'h00);
    cyc(10);
    @(posedge clk_sys);
    offhookPin <= 1'b1;
    cyc(3);
    hook(1'b0);
    @(posedge clk_sys);
    offhookPinEnable <= 1'b1;
    cyc(3);
    hook(1'b1);
    for (int m = 1; m >= 0; m--) begin
      @(posedge clk_sys);
      lineModeBit <= m[0];
      offhookPin <= 1'b0;
      @(posedge clk_sys);
      offhookPin <= 1'b1;
      cyc(2);
      hook(m[0]);
      cyc(10);
      hook(1'b1);
    end
    // A hardware reset in mid-run must clear the sticky serial width bit.
    host.writeReg(8'h01, 8'h01);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h01, 8'h00);
    cyc(5);
    chk("pendingReads", 8'h00, 8'(expQ.size()));
    completeRun();
  end
endmodule // testbench
